// [rtl/ppio_ports.v]
// parallel ports one to four with apb register access
// Summary of operation
// - first port: eight pins, data and direction
// - direction one drives pin, zero inputs
// - direction registers clear to zero on reset
// - data registers untouched by reset
// - second, third port data accessible only in single/boot modes
// - alternate function: write updates register, not pin
// - first port bits shared with timer channels
// - bit3 compare5/compare1/capture4; bit7 accumulator/compare1
// - expanded/test: second port drives high address
// - single/boot: second port general i/o by direction, pull-ups selectable
// - expanded/test: third port is data bus
// - single/boot: third port general i/o by direction, no pull-ups
// - fourth port six bits, serial and spi
// - fourth port bits 7 and 6 read zero
// - first, fourth ports come up as inputs
`timescale 1ns/10ps
`default_nettype none
`include "ppio_defines.vh"

module ppio_ports #(
  parameter W  = 8,
  parameter DW = 6
) (
  input  wire        clk,
  input  wire        reset,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [1:0]  op_mode,
  input  wire [W-1:0]  first_port_in,
  output reg  [W-1:0]  first_port_out,
  output reg  [W-1:0]  first_port_oe_n,
  input  wire [W-1:0]  timer_claim,
  input  wire [W-1:0]  timer_out,
  input  wire [W-1:0]  timer_drive,
  output reg  [W-1:0]  timer_in,
  input  wire [W-1:0]  second_port_in,
  output reg  [W-1:0]  second_port_out,
  output reg  [W-1:0]  second_port_oe_n,
  output reg  [W-1:0]  second_port_pullup,
  input  wire [W-1:0]  pullup_select,
  input  wire [W-1:0]  high_address,
  input  wire [W-1:0]  third_port_in,
  output reg  [W-1:0]  third_port_out,
  output reg  [W-1:0]  third_port_oe_n,
  input  wire [W-1:0]  bus_data_out,
  input  wire          bus_data_drive,
  output reg  [W-1:0]  bus_data_in,
  input  wire [DW-1:0] fourth_port_in,
  output reg  [DW-1:0] fourth_port_out,
  output reg  [DW-1:0] fourth_port_oe_n,
  input  wire [DW-1:0] serial_claim,
  input  wire [DW-1:0] serial_out,
  input  wire [DW-1:0] serial_drive,
  output reg  [DW-1:0] serial_in
);

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  reg  [W-1:0]  first_port_data;
  reg  [W-1:0]  first_port_direction;
  reg  [W-1:0]  second_port_data;
  reg  [W-1:0]  second_port_direction;
  reg  [W-1:0]  third_port_data;
  reg  [W-1:0]  third_port_direction;
  reg  [DW-1:0] fourth_port_data;
  reg  [DW-1:0] fourth_port_direction;

  // three-stage pin samplers, stage one feeds only stage two
  reg  [W-1:0]  a_s1, a_s2, a_s3, a_pin;
  reg  [W-1:0]  b_s1, b_s2, b_s3, b_pin;
  reg  [W-1:0]  c_s1, c_s2, c_s3, c_pin;
  reg  [DW-1:0] d_s1, d_s2, d_s3, d_pin;
  reg  [1:0]    mode_s1, mode_s2, mode_s3, mode;

  wire          expanded;
  wire          access;
  wire [7:0]    idx;
  wire          addr_ok;
  wire          mapped;
  reg  [W-1:0]  next_rdata;
  reg           next_hit;

  assign expanded = (mode == `PPIO_MODE_EXPAND) || (mode == `PPIO_MODE_TEST);
  assign access   = psel & penable;
  assign idx      = paddr[9:2];
  assign addr_ok  = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  assign mapped   = addr_ok & next_hit;

  // ----------------------------------------------------------------------
  // input synchronisers: a change counts when stages two and three agree
  // ----------------------------------------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      a_s1 <= 8'h00; a_s2 <= 8'h00; a_s3 <= 8'h00; a_pin <= 8'h00;
      b_s1 <= 8'h00; b_s2 <= 8'h00; b_s3 <= 8'h00; b_pin <= 8'h00;
      c_s1 <= 8'h00; c_s2 <= 8'h00; c_s3 <= 8'h00; c_pin <= 8'h00;
      d_s1 <= 6'h00; d_s2 <= 6'h00; d_s3 <= 6'h00; d_pin <= 6'h00;
      mode_s1 <= `PPIO_MODE_SINGLE;
      mode_s2 <= `PPIO_MODE_SINGLE;
      mode_s3 <= `PPIO_MODE_SINGLE;
      mode    <= `PPIO_MODE_SINGLE;
    end else begin
      a_s1 <= first_port_in;  a_s2 <= a_s1; a_s3 <= a_s2;
      b_s1 <= second_port_in; b_s2 <= b_s1; b_s3 <= b_s2;
      c_s1 <= third_port_in;  c_s2 <= c_s1; c_s3 <= c_s2;
      d_s1 <= fourth_port_in; d_s2 <= d_s1; d_s3 <= d_s2;
      mode_s1 <= op_mode; mode_s2 <= mode_s1; mode_s3 <= mode_s2;
      // per-bit agreement filter
      a_pin <= (a_s2 & a_s3) | (a_pin & (a_s2 | a_s3));
      b_pin <= (b_s2 & b_s3) | (b_pin & (b_s2 | b_s3));
      c_pin <= (c_s2 & c_s3) | (c_pin & (c_s2 | c_s3));
      d_pin <= (d_s2 & d_s3) | (d_pin & (d_s2 | d_s3));
      if (mode_s2 == mode_s3)
        mode <= mode_s3;
    end
  end

  // ----------------------------------------------------------------------
  // read decode; second and third ports leave the map when expanded
  // ----------------------------------------------------------------------
  always @* begin
    next_rdata = 8'h00;
    next_hit   = 1'b1;
    case (idx)
      // input bits show the pin, output bits the latch
      `PPIO_IDX_A_DATA: next_rdata = (first_port_data & first_port_direction) |
                                     (a_pin & ~first_port_direction);
      `PPIO_IDX_A_DIR:  next_rdata = first_port_direction;
      `PPIO_IDX_B_DATA: begin
        next_hit   = ~expanded;
        next_rdata = (second_port_data & second_port_direction) |
                     (b_pin & ~second_port_direction);
      end
      `PPIO_IDX_B_DIR: begin
        next_hit   = ~expanded;
        next_rdata = second_port_direction;
      end
      `PPIO_IDX_C_DATA: begin
        next_hit   = ~expanded;
        next_rdata = (third_port_data & third_port_direction) |
                     (c_pin & ~third_port_direction);
      end
      `PPIO_IDX_C_DIR: begin
        next_hit   = ~expanded;
        next_rdata = third_port_direction;
      end
      // upper two bits tie to zero
      `PPIO_IDX_D_DATA: next_rdata = {2'b00, (fourth_port_data & fourth_port_direction) |
                                             (d_pin & ~fourth_port_direction)};
      `PPIO_IDX_D_DIR:  next_rdata = {2'b00, fourth_port_direction};
      `PPIO_IDX_MODE:   next_rdata = {6'h00, mode};
      default:          next_hit   = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // apb slave: one wait state, answer on the second access cycle
  // ----------------------------------------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access & ~pready;
      pslverr <= access & ~pready & ~mapped;
      if (access & ~pready & ~pwrite & mapped)
        prdata <= {24'h00_0000, next_rdata};
      else
        prdata <= 32'h0000_0000;
    end
  end

  // data latches carry no reset so they keep contents
  always @(posedge clk) begin
    if (access & pready & pwrite & addr_ok) begin
      // writes land even while a pin is claimed
      if (idx == `PPIO_IDX_A_DATA)
        first_port_data <= pwdata[W-1:0];
      if ((idx == `PPIO_IDX_B_DATA) && !expanded)
        second_port_data <= pwdata[W-1:0];
      if ((idx == `PPIO_IDX_C_DATA) && !expanded)
        third_port_data <= pwdata[W-1:0];
      if (idx == `PPIO_IDX_D_DATA)
        fourth_port_data <= pwdata[DW-1:0];
    end
  end

  // direction registers clear on reset, pins come up as inputs
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      first_port_direction  <= `PPIO_DIR_RESET;
      second_port_direction <= `PPIO_DIR_RESET;
      third_port_direction  <= `PPIO_DIR_RESET;
      fourth_port_direction <= 6'h00;
    end else if (access & pready & pwrite & addr_ok) begin
      if (idx == `PPIO_IDX_A_DIR)
        first_port_direction <= pwdata[W-1:0];
      if ((idx == `PPIO_IDX_B_DIR) && !expanded)
        second_port_direction <= pwdata[W-1:0];
      if ((idx == `PPIO_IDX_C_DIR) && !expanded)
        third_port_direction <= pwdata[W-1:0];
      if (idx == `PPIO_IDX_D_DIR)
        fourth_port_direction <= pwdata[DW-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // pin drivers; every output is registered, so pins lag one cycle
  // ----------------------------------------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      first_port_out     <= 8'h00;
      first_port_oe_n    <= 8'hff;
      second_port_out    <= 8'h00;
      second_port_oe_n   <= 8'hff;
      second_port_pullup <= 8'h00;
      third_port_out     <= 8'h00;
      third_port_oe_n    <= 8'hff;
      fourth_port_out    <= 6'h00;
      fourth_port_oe_n   <= 6'h3f;
      timer_in           <= 8'h00;
      serial_in          <= 6'h00;
      bus_data_in        <= 8'h00;
    end else begin
      // timer owns claimed bits; pins 0..2 captures, 3..7 compares
      first_port_out  <= (timer_claim & timer_out) | (~timer_claim & first_port_data);
      first_port_oe_n <= ~((timer_claim & timer_drive) |
                           (~timer_claim & first_port_direction));
      timer_in        <= a_pin;
      // serial and spi own claimed bits of the fourth port
      fourth_port_out  <= (serial_claim & serial_out) | (~serial_claim & fourth_port_data);
      fourth_port_oe_n <= ~((serial_claim & serial_drive) |
                            (~serial_claim & fourth_port_direction));
      serial_in        <= d_pin;
      if (expanded) begin
        second_port_out    <= high_address;
        second_port_oe_n   <= 8'h00;
        second_port_pullup <= 8'h00;
        third_port_out     <= bus_data_out;
        third_port_oe_n    <= {W{~bus_data_drive}};
      end else begin
        second_port_out    <= second_port_data;
        second_port_oe_n   <= ~second_port_direction;
        second_port_pullup <= pullup_select & ~second_port_direction;
        third_port_out     <= third_port_data;
        third_port_oe_n    <= ~third_port_direction;
      end
      bus_data_in <= c_pin;
    end
  end

endmodule
`default_nettype wire

// [inc/ppio_defines.vh]
// register offsets, widths and mode codes for the parallel port block
`ifndef PPIO_DEFINES_VH
`define PPIO_DEFINES_VH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define PPIO_IDX_A_DATA   8'h00
`define PPIO_IDX_A_DIR    8'h01
`define PPIO_IDX_B_DIR    8'h02
`define PPIO_IDX_B_DATA   8'h04
`define PPIO_IDX_C_DATA   8'h06
`define PPIO_IDX_C_DIR    8'h07
`define PPIO_IDX_D_DATA   8'h08
`define PPIO_IDX_D_DIR    8'h09
`define PPIO_IDX_MODE     8'h10

// ----------------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------------
`define PPIO_DIR_RESET    8'h00
`define PPIO_D_MASK       8'h3f
`define PPIO_DATA_W       8
`define PPIO_D_W          6
`define PPIO_MODE_W       2

// operating modes
`define PPIO_MODE_SINGLE  2'h0
`define PPIO_MODE_EXPAND  2'h1
`define PPIO_MODE_BOOT    2'h2
`define PPIO_MODE_TEST    2'h3

`endif

// [dv/ppio_ports_props.sv]
// checker for the apb handshake and pin ownership of the parallel ports
`timescale 1ns/10ps
`default_nettype none
module ppio_ports_props #(
  parameter W  = 8,
  parameter DW = 6
) (
  input wire logic          clk,
  input wire logic          reset,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [11:0]   paddr,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic [1:0]    op_mode,
  input wire logic [W-1:0]  first_port_out,
  input wire logic [W-1:0]  first_port_oe_n,
  input wire logic [W-1:0]  timer_claim,
  input wire logic [W-1:0]  timer_out,
  input wire logic [W-1:0]  timer_drive,
  input wire logic [W-1:0]  second_port_out,
  input wire logic [W-1:0]  second_port_oe_n,
  input wire logic [W-1:0]  second_port_pullup,
  input wire logic [W-1:0]  pullup_select,
  input wire logic [W-1:0]  high_address,
  input wire logic [DW-1:0] fourth_port_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------------
  // bus answer, reset state and pin ownership
  // ----------------------------------------------------------------------
  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("ready late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("lone error");
  a_d_upper_zero: assert property (pready && !pwrite && (paddr == 12'h020 || paddr == 12'h024)
    |-> prdata[31:6] == 26'h0) else $error("port d upper bits set");
  a_reset_inputs: assert property ($fell(reset) |-> &first_port_oe_n && &fourth_port_oe_n)
    else $error("pins driven after reset");
  // peripheral owns claimed bits once its inputs have settled
  a_timer_owns_pin: assert property (($stable(timer_claim) && $stable(timer_out)
    && $stable(timer_drive))[*2] |-> ((first_port_out ^ timer_out) & timer_claim) == 8'h0
    && ((first_port_oe_n ^ ~timer_drive) & timer_claim) == 8'h0)
    else $error("timer pin wrong");
  // mode passes a synchroniser, so allow eight settled cycles
  a_high_addr_out: assert property ((op_mode[0] && $stable(high_address))[*8]
    |-> second_port_out == high_address && second_port_oe_n == 8'h0)
    else $error("high address missing");
  a_pullup_sel: assert property ((!op_mode[0] && $stable(pullup_select))[*8]
    |-> second_port_pullup == (pullup_select & second_port_oe_n))
    else $error("pull-up wrong");
  c_refused: cover property (pslverr);
  c_write: cover property (pready && pwrite);
  c_expanded: cover property (op_mode[0] && second_port_oe_n == 8'h0);
endmodule
`default_nettype wire

// [dv/ppio_pin_model.sv]
// far side of one port: outside drivers, pull-ups and floating pins
`timescale 1ns/10ps
`default_nettype none
module ppio_pin_model #(
  parameter W = 8
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] out,
  input  wire logic [W-1:0] oe_n,
  input  wire logic [W-1:0] pull_en,
  input  wire logic [W-1:0] ext,
  input  wire logic [W-1:0] ext_en,
  output var  logic [W-1:0] pin
);
  logic tog = 1'b0;
  // an undriven pin wanders each cycle so a stale level never passes
  always @(posedge clk) tog <= ~tog;
  assign pin = (~oe_n & out) | (oe_n & ext_en & ext) | (oe_n & ~ext_en & (pull_en | {W{tog}}));
endmodule
`default_nettype wire

// [dv/ppio_ports_test.sv]
// self-checking bench for the parallel ports over apb
`timescale 1ns/10ps
`default_nettype none
module ppio_ports_test;
  logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic bus_data_drive = 1'b1, rd_err;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd_data;
  logic [1:0] op_mode = 2'h0;
  logic [7:0] first_port_in, first_port_out, first_port_oe_n, timer_in, ext_a = 8'h3c;
  logic [7:0] timer_claim = 8'h0, timer_out = 8'h0, timer_drive = 8'h0, bus_data_in;
  logic [7:0] second_port_in, second_port_out, second_port_oe_n, second_port_pullup;
  logic [7:0] pullup_select = 8'hff, high_address = 8'h81, bus_data_out = 8'h42;
  logic [7:0] third_port_in, third_port_out, third_port_oe_n;
  logic [5:0] fourth_port_in, fourth_port_out, fourth_port_oe_n, serial_in;
  logic [5:0] serial_claim = 6'h0, serial_out = 6'h0, serial_drive = 6'h0;
  logic [11:0] dirs [4] = '{12'h004, 12'h008, 12'h01c, 12'h024};
  // far-side levels of each pin model, kept as variables so a scenario can move them
  logic [7:0] pu_a = 8'h0, en_a = 8'hff, ext_b = 8'h0, en_b = 8'h0;
  logic [7:0] pu_c = 8'h0, ext_c = 8'h0, en_c = 8'h0;
  logic [5:0] pu_d = 6'h0, ext_d = 6'h15, en_d = 6'h3f;
  int error_cnt = 0, n_checks = 0;
  always #2 clk = ~clk;
  ppio_ports uut (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .op_mode, .first_port_in, .first_port_out, .first_port_oe_n, .timer_claim,
    .timer_out, .timer_drive, .timer_in, .second_port_in, .second_port_out, .second_port_oe_n,
    .second_port_pullup, .pullup_select, .high_address, .third_port_in, .third_port_out,
    .third_port_oe_n, .bus_data_out, .bus_data_drive, .bus_data_in, .fourth_port_in,
    .fourth_port_out, .fourth_port_oe_n, .serial_claim, .serial_out, .serial_drive, .serial_in);
  ppio_pin_model #(.W(8)) m_a (.clk, .out(first_port_out), .oe_n(first_port_oe_n),
    .pull_en(pu_a), .ext(ext_a), .ext_en(en_a), .pin(first_port_in));
  ppio_pin_model #(.W(8)) m_b (.clk, .out(second_port_out), .oe_n(second_port_oe_n),
    .pull_en(second_port_pullup), .ext(ext_b), .ext_en(en_b), .pin(second_port_in));
  ppio_pin_model #(.W(8)) m_c (.clk, .out(third_port_out), .oe_n(third_port_oe_n),
    .pull_en(pu_c), .ext(ext_c), .ext_en(en_c), .pin(third_port_in));
  ppio_pin_model #(.W(6)) m_d (.clk, .out(fourth_port_out), .oe_n(fourth_port_oe_n),
    .pull_en(pu_d), .ext(ext_d), .ext_en(en_d), .pin(fourth_port_in));
  // ----------------------------------------------------------------------
  // bus tasks: one apb transfer, answer taken at the ready edge
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic [11:0] a, input logic w, input logic [31:0] d,
                     input logic [31:0] exp, input logic err);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so the next call never reassigns in this step
    @(posedge clk);
    if (!w) chk(rd_data, exp);
    chk({31'h0, rd_err}, {31'h0, err});
  endtask
  task automatic end_sim;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog well beyond the fewer than two hundred cycles the run needs
  initial begin
    #40000;
    error_cnt++;
    end_sim();
  end
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk({first_port_oe_n, second_port_oe_n, third_port_oe_n}, 24'hffffff);
    foreach (dirs[i]) acc(dirs[i], 1'b0, 32'h0, 32'h0, 1'b0);
    acc(12'h004, 1'b1, 32'hf0, 32'h0, 1'b0);
    acc(12'h000, 1'b1, 32'h1a5, 32'h0, 1'b0);
    repeat (6) @(posedge clk);
    chk({first_port_oe_n, first_port_out[7:4]}, 12'h0fa);
    acc(12'h000, 1'b0, 32'h0, 32'hac, 1'b0);
    timer_claim <= 8'h88;
    timer_drive <= 8'h88;
    acc(12'h004, 1'b1, 32'hff, 32'h0, 1'b0);
    acc(12'h000, 1'b1, 32'hff, 32'h0, 1'b0);
    // pins follow the register one edge after the write lands
    @(posedge clk);
    chk(first_port_out, 32'h77);
    acc(12'h000, 1'b0, 32'h0, 32'hff, 1'b0);
    timer_claim <= 8'h0;
    acc(12'h010, 1'b1, 32'h5a, 32'h0, 1'b0);
    acc(12'h008, 1'b1, 32'hff, 32'h0, 1'b0);
    acc(12'h010, 1'b0, 32'h0, 32'h5a, 1'b0);
    acc(12'h018, 1'b1, 32'hc3, 32'h0, 1'b0);
    acc(12'h01c, 1'b1, 32'hff, 32'h0, 1'b0);
    serial_claim <= 6'h03;
    serial_drive <= 6'h02;
    acc(12'h024, 1'b1, 32'hff, 32'h0, 1'b0);
    acc(12'h020, 1'b1, 32'hff, 32'h0, 1'b0);
    @(posedge clk);
    chk({fourth_port_out[5:2], fourth_port_oe_n}, 10'h3c1);
    acc(12'h024, 1'b0, 32'h0, 32'h3f, 1'b0);
    acc(12'h020, 1'b0, 32'h0, 32'h3f, 1'b0);
    acc(12'h02c, 1'b0, 32'h0, 32'h0, 1'b1); // unmapped index is refused
    serial_claim <= 6'h0;
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    acc(12'h008, 1'b1, 32'hff, 32'h0, 1'b0);
    acc(12'h010, 1'b0, 32'h0, 32'h5a, 1'b0);
    acc(12'h01c, 1'b1, 32'hff, 32'h0, 1'b0);
    // peripheral-facing copies of the synchronised first and fourth port pins
    chk({timer_in, serial_in}, {8'h3c, 6'h15});
    for (int m = 0; m < 4; m++) begin
      op_mode <= m[1:0];
      repeat (10) @(posedge clk);
      chk({second_port_oe_n, third_port_oe_n, second_port_out & {8{m[0]}},
           third_port_out & {8{m[0]}}}, m[0] ? 32'h00008142 : 32'h00000000);
      acc(12'h018, 1'b0, 32'h0, m[0] ? 32'h0 : 32'hc3, m[0]);
      chk(bus_data_in, m[0] ? 32'h42 : 32'hc3);
      acc(12'h040, 1'b0, 32'h0, {30'h0, m[1:0]}, 1'b0);
    end
    end_sim();
  end
endmodule
bind ppio_ports ppio_ports_props #(.W(W), .DW(DW)) u_props (.clk, .reset, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .op_mode, .first_port_out, .first_port_oe_n,
  .timer_claim, .timer_out, .timer_drive, .second_port_out, .second_port_oe_n,
  .second_port_pullup, .pullup_select, .high_address, .fourth_port_oe_n);
`default_nettype wire
